/* File: core/gct_cmd_tx.sv */
// Controller-side command byte transmitter with settings and status
`timescale 1ns/1ns
`default_nettype none
module gct_cmd_tx
  import gct_pkg::*;
#(
  parameter int TMO_CYCLES = TMO_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic op_start,
  input wire logic [2:0] op_code,
  input wire logic [15:0] op_value,
  output logic op_done,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cfg_is_cic,
  input wire logic cfg_sys_ctrl,
  input wire logic cfg_host_dma,
  input wire logic [1:0] cfg_dma_channel,
  input wire logic cfg_dma_default,
  input wire logic [15:0] cfg_eos_default,
  input wire logic [4:0] cfg_dev_addr,
  input wire logic cfg_sad_en,
  input wire logic [4:0] cfg_sad,
  output logic [15:0] status_word,
  output logic [15:0] transfer_count,
  output logic [15:0] error_code_word,
  output logic dma_enable,
  output logic [1:0] dma_channel,
  output logic [15:0] string_end_setting,
  input wire logic [7:0] rd_byte,
  output logic rd_end,
  input wire logic [7:0] wr_byte,
  output logic wr_eoi,
  output logic [7:0] dio_n_out,
  output logic dio_oe,
  output logic dav_n_out,
  output logic dav_oe,
  output logic atn_n,
  input wire logic nrfd_n,
  input wire logic ndac_n,
  input wire logic ifc_n
);
  localparam int TW = $clog2(TMO_CYCLES + 1);

  typedef enum logic [2:0] {
    S_IDLE, S_TAKE, S_LOAD, S_SETTLE, S_RFD, S_DAV, S_REL, S_DONE
  } gct_state_t;

  gct_state_t state;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic active_ctl;
  logic async_mode;
  logic clr_mode;
  logic [15:0] req_cnt;
  logic [15:0] sent_cnt;
  logic [7:0] tx_byte;
  logic [7:0] settle_cnt;
  logic [TW-1:0] tmo_cnt;
  logic end_err;
  logic end_tmo;
  logic end_tct;
  logic end_stop;
  logic fifo_flush;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;
  logic [7:0] clr_byte;
  logic [2:0] clr_idx;
  logic [7:0] next_byte;
  logic rd_match;
  logic wr_match;
  logic busy;
  logic moving;
  logic bus_rfd;
  logic bus_acc;
  logic ifc_stop;
  logic tmo_hit;
  logic settle_done;
  logic dma_ok;

  // Second stage only feeds logic; first stage is read by nothing else
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
    end else begin
      pin_meta <= {ifc_n, ndac_n, nrfd_n};
      pin_sync <= pin_meta;
    end
  end

  assign bus_rfd = pin_sync[0];
  assign bus_acc = pin_sync[1];
  // IFC from us as system controller does not end our own transfer
  assign ifc_stop = !pin_sync[2] && !cfg_sys_ctrl;
  assign busy = state != S_IDLE;
  assign moving = busy && state != S_DONE;
  assign tmo_hit = tmo_cnt == TW'(TMO_CYCLES - 1);
  assign settle_done = settle_cnt == 8'(SETTLE_CYC - 1);
  assign dma_ok = cfg_host_dma && cfg_dma_channel != 2'h0;

  // Clear sequence, skipping the secondary slot when none is set
  always_comb begin
    clr_idx = sent_cnt[2:0];
    if (!cfg_sad_en && clr_idx != 3'h0) begin
      clr_idx = sent_cnt[2:0] + 3'h1;
    end
    case (clr_idx)
      3'h0: clr_byte = CMD_LAD_BASE | {3'h0, cfg_dev_addr};
      3'h1: clr_byte = CMD_SAD_BASE | {3'h0, cfg_sad};
      3'h2: clr_byte = CMD_SDC;
      3'h3: clr_byte = CMD_UNT;
      default: clr_byte = CMD_UNL;
    endcase
  end

  // Host bytes pass untouched; no re-encoding of interface messages
  assign next_byte = clr_mode ? clr_byte : fifo_data;
  assign fifo_pop = state == S_LOAD && !clr_mode && fifo_valid && sent_cnt != req_cnt
    && !(op_start && op_code == OP_STOP) && !ifc_stop && cfg_is_cic && !tmo_hit
    && !(op_start && op_code == OP_ONL);

  gct_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .flush(fifo_flush),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data(cmd_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  gct_eos_match u_rd_match (
    .data_byte(rd_byte),
    .setting(string_end_setting),
    .rd_end(rd_match),
    .wr_eoi()
  );

  gct_eos_match u_wr_match (
    .data_byte(wr_byte),
    .setting(string_end_setting),
    .rd_end(),
    .wr_eoi(wr_match)
  );

  // Registered end-string indications toward the data engines
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rd_end <= 1'b0;
      wr_eoi <= 1'b0;
    end else begin
      rd_end <= rd_match;
      wr_eoi <= wr_match;
    end
  end

  // Whole-transfer time limit; saturates so a stuck bus cannot wrap it
  always_ff @(posedge clk_sys) begin
    if (!resetn || !moving) begin
      tmo_cnt <= '0;
    end else if (!tmo_hit) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end
  end

  // Operation decode, settings and the byte engine
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= S_IDLE;
      op_done <= 1'b0;
      status_word <= WORD_RST;
      transfer_count <= WORD_RST;
      error_code_word <= WORD_RST;
      dma_enable <= cfg_dma_default && dma_ok;
      dma_channel <= cfg_dma_channel;
      string_end_setting <= cfg_eos_default;
      dio_n_out <= BYTE_IDLE_N;
      dio_oe <= 1'b0;
      dav_n_out <= 1'b1;
      dav_oe <= 1'b0;
      atn_n <= 1'b1;
      active_ctl <= 1'b0;
      async_mode <= 1'b0;
      clr_mode <= 1'b0;
      req_cnt <= WORD_RST;
      sent_cnt <= WORD_RST;
      tx_byte <= 8'h00;
      settle_cnt <= 8'h00;
      end_err <= 1'b0;
      end_tmo <= 1'b0;
      end_tct <= 1'b0;
      end_stop <= 1'b0;
      fifo_flush <= 1'b0;
    end else begin
      op_done <= 1'b0;
      fifo_flush <= 1'b0;
      dma_channel <= cfg_dma_channel;
      status_word[ST_CIC] <= cfg_is_cic;
      status_word[ST_ATN] <= active_ctl;
      if (op_start && op_code == OP_ONL) begin
        // Online reset cancels any transfer and restores defaults
        state <= S_IDLE;
        op_done <= 1'b1;
        dma_enable <= cfg_dma_default && dma_ok;
        string_end_setting <= cfg_eos_default;
        status_word[ST_ERR] <= 1'b0;
        status_word[ST_TIMO] <= 1'b0;
        status_word[ST_COMPLETION_FLAG] <= 1'b0;
        dio_oe <= 1'b0;
        dav_n_out <= 1'b1;
        dav_oe <= 1'b0;
        atn_n <= 1'b1;
        active_ctl <= 1'b0;
        fifo_flush <= 1'b1;
      end else if (!busy) begin
        if (op_start) begin
          case (op_code)
            OP_CMD, OP_CMDA, OP_CLR: begin
              if (!cfg_is_cic) begin
                op_done <= 1'b1;
                status_word[ST_ERR] <= 1'b1;
                error_code_word <= ERR_NOT_CIC;
              end else begin
                clr_mode <= op_code == OP_CLR;
                async_mode <= op_code == OP_CMDA;
                req_cnt <= op_code == OP_CLR ?
                  (cfg_sad_en ? CLR_LEN_SAD : CLR_LEN_NOSAD) : op_value;
                sent_cnt <= WORD_RST;
                status_word[ST_ERR] <= 1'b0;
                status_word[ST_TIMO] <= 1'b0;
                status_word[ST_COMPLETION_FLAG] <= 1'b0;
                end_err <= 1'b0;
                end_tmo <= 1'b0;
                end_tct <= 1'b0;
                end_stop <= 1'b0;
                settle_cnt <= 8'h00;
                dav_oe <= 1'b1;
                dav_n_out <= 1'b1;
                state <= active_ctl ? S_LOAD : S_TAKE;
                op_done <= op_code == OP_CMDA;
              end
            end
            OP_DMA: begin
              op_done <= 1'b1;
              if (op_value != WORD_RST && !dma_ok) begin
                status_word[ST_ERR] <= 1'b1;
                error_code_word <= ERR_NO_CAP;
              end else if (cfg_host_dma) begin
                status_word[ST_ERR] <= 1'b0;
                error_code_word <= {15'h0000, dma_enable};
                dma_enable <= op_value != WORD_RST;
              end else begin
                // No DMA on this host: zero request only clears the error bit
                status_word[ST_ERR] <= 1'b0;
              end
            end
            OP_EOS: begin
              op_done <= 1'b1;
              status_word[ST_ERR] <= 1'b0;
              error_code_word <= string_end_setting;
              string_end_setting <= op_value;
            end
            default: begin
              op_done <= 1'b1;
            end
          endcase
        end
      end else begin
        if (op_start && op_code != OP_STOP && op_code != OP_WAIT) begin
          op_done <= 1'b1;
          error_code_word <= ERR_PENDING;
        end else if (op_start) begin
          op_done <= 1'b1;
        end
        if (moving && (op_start && op_code == OP_STOP)) begin
          end_stop <= 1'b1;
          state <= S_DONE;
        end else if (moving && (ifc_stop || !cfg_is_cic || tmo_hit)) begin
          end_err <= !cfg_is_cic;
          end_tmo <= cfg_is_cic && !ifc_stop && tmo_hit;
          state <= S_DONE;
        end else begin
          case (state)
            S_TAKE: begin
              // ATN settles before the first byte is placed
              atn_n <= 1'b0;
              active_ctl <= 1'b1;
              settle_cnt <= settle_cnt + 8'h01;
              if (settle_done) begin
                settle_cnt <= 8'h00;
                state <= S_LOAD;
              end
            end
            S_LOAD: begin
              dav_n_out <= 1'b1;
              settle_cnt <= 8'h00;
              if (sent_cnt == req_cnt) begin
                state <= S_DONE;
              end else if (clr_mode || fifo_valid) begin
                tx_byte <= next_byte;
                dio_n_out <= ~next_byte;
                dio_oe <= 1'b1;
                state <= S_SETTLE;
              end
            end
            S_SETTLE: begin
              settle_cnt <= settle_cnt + 8'h01;
              if (settle_done) begin
                state <= S_RFD;
              end
            end
            S_RFD: begin
              // All acceptors ready before data is declared valid
              if (bus_rfd) begin
                dav_n_out <= 1'b0;
                state <= S_DAV;
              end
            end
            S_DAV: begin
              // Released NDAC counts as accepted even with no listener
              if (bus_acc) begin
                dav_n_out <= 1'b1;
                sent_cnt <= sent_cnt + 16'h0001;
                if (tx_byte == CMD_TCT) begin
                  end_tct <= 1'b1;
                  state <= S_DONE;
                end else begin
                  state <= S_REL;
                end
              end
            end
            S_REL: begin
              if (!bus_acc) begin
                state <= S_LOAD;
              end
            end
            S_DONE: begin
              transfer_count <= sent_cnt;
              status_word[ST_COMPLETION_FLAG] <= 1'b1;
              status_word[ST_ERR] <= end_err;
              status_word[ST_TIMO] <= end_tmo;
              if (end_err) begin
                error_code_word <= ERR_NOT_CIC;
              end
              dio_oe <= 1'b0;
              dio_n_out <= BYTE_IDLE_N;
              dav_n_out <= 1'b1;
              dav_oe <= 1'b0;
              if (end_tct) begin
                // Control passed away; ATN released
                active_ctl <= 1'b0;
                atn_n <= 1'b1;
              end
              fifo_flush <= 1'b1;
              op_done <= !async_mode && !end_stop;
              state <= S_IDLE;
            end
            default: begin
              state <= S_IDLE;
            end
          endcase
        end
      end
    end
  end
endmodule : gct_cmd_tx
`default_nettype wire

/* File: core/gct_pkg.sv */
// Constants shared by the command transmitter and its helpers
package gct_pkg;
  // Clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TMO_MS = 10;
  localparam int TMO_CYC_DEF = TMO_MS * (CLK_HZ / 1000);

  // Command FIFO shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  // Host operation codes
  localparam logic [2:0] OP_CMD = 3'h0;
  localparam logic [2:0] OP_CMDA = 3'h1;
  localparam logic [2:0] OP_CLR = 3'h2;
  localparam logic [2:0] OP_DMA = 3'h3;
  localparam logic [2:0] OP_EOS = 3'h4;
  localparam logic [2:0] OP_STOP = 3'h5;
  localparam logic [2:0] OP_WAIT = 3'h6;
  localparam logic [2:0] OP_ONL = 3'h7;

  // Status word bit positions
  localparam int ST_ERR = 15;
  localparam int ST_TIMO = 14;
  localparam int ST_COMPLETION_FLAG = 8;
  localparam int ST_CIC = 5;
  localparam int ST_ATN = 4;

  // Error code word values
  localparam logic [15:0] ERR_NOT_CIC = 16'h0001;
  localparam logic [15:0] ERR_PENDING = 16'h000A;
  localparam logic [15:0] ERR_NO_CAP = 16'h000B;

  // Interface message codes
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_TCT = 8'h09;
  localparam logic [7:0] CMD_UNT = 8'h5F;
  localparam logic [7:0] CMD_UNL = 8'h3F;
  localparam logic [7:0] CMD_LAD_BASE = 8'h20;
  localparam logic [7:0] CMD_SAD_BASE = 8'h60;

  // Clear sequence lengths
  localparam logic [15:0] CLR_LEN_SAD = 16'h0005;
  localparam logic [15:0] CLR_LEN_NOSAD = 16'h0004;

  // End-of-string setting field positions
  localparam int EOS_RD_BIT = 10;
  localparam int EOS_WR_BIT = 11;
  localparam int EOS_BIN_BIT = 12;

  // Values after reset
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] BYTE_IDLE_N = 8'hFF;
endpackage : gct_pkg

/* File: core/gct_fifo.sv */
// Command byte FIFO with registered flags
`timescale 1ns/1ns
`default_nettype none
module gct_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  // Occupancy next value
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage; no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and flags registered so ready never glitches
  always_ff @(posedge clk_sys) begin
    if (!resetn || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count != (AW + 1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule : gct_fifo
`default_nettype wire

/* File: core/gct_eos_match.sv */
// End-of-string compare for read termination and write EOI
`timescale 1ns/1ns
`default_nettype none
module gct_eos_match
  import gct_pkg::*;
(
  input wire logic [7:0] data_byte,
  input wire logic [15:0] setting,
  output logic rd_end,
  output logic wr_eoi
);
  logic hit;

  // Seven-bit compare unless the full-byte option is on
  always_comb begin
    if (setting[EOS_BIN_BIT]) begin
      hit = data_byte == setting[7:0];
    end else begin
      hit = data_byte[6:0] == setting[6:0];
    end
    rd_end = hit && setting[EOS_RD_BIT];
    wr_eoi = hit && setting[EOS_WR_BIT];
  end
endmodule : gct_eos_match
`default_nettype wire

/* File: verification/gct_cmd_tx_monitor.sv */
// Port checker for the command transmitter
`timescale 1ns/1ns
`default_nettype none
module gct_cmd_tx_monitor
  import gct_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic op_start,
  input wire logic [2:0] op_code,
  input wire logic op_done,
  input wire logic cfg_is_cic,
  input wire logic [15:0] status_word,
  input wire logic [15:0] error_code_word,
  input wire logic [15:0] string_end_setting,
  input wire logic [7:0] rd_byte,
  input wire logic rd_end,
  input wire logic [7:0] wr_byte,
  input wire logic wr_eoi,
  input wire logic [7:0] dio_n_out,
  input wire logic dio_oe,
  input wire logic dav_n_out,
  input wire logic dav_oe,
  input wire logic atn_n,
  input wire logic nrfd_n,
  input wire logic ndac_n
);
  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  logic exp_rd;
  logic exp_wr;

  // Low seven bits always, bit 7 only under full-byte compare
  function automatic logic hit(input logic [7:0] b, input logic [15:0] s);
    return (b[6:0] == s[6:0]) && (!s[EOS_BIN_BIT] || (b[7] == s[7]));
  endfunction : hit

  // Expected end flags, one cycle behind their inputs
  always_ff @(posedge clk_sys) begin
    exp_rd <= string_end_setting[EOS_RD_BIT] && hit(rd_byte, string_end_setting);
    exp_wr <= string_end_setting[EOS_WR_BIT] && hit(wr_byte, string_end_setting);
  end

  // Taking control, then a quiet bus before the first byte
  sequence s_take;
    $fell(atn_n);
  endsequence
  sequence s_quiet;
    dav_n_out [*8];
  endsequence

  a_take_settle: assert property (s_take |-> s_quiet)
    else $error("data valid too soon after taking control");
  a_dav_owned: assert property (!dav_n_out |-> dio_oe && dav_oe && !atn_n)
    else $error("data valid without owned bus");
  // Pin inputs reach the engine through two flops, so look three samples back
  a_ready_first: assert property ($fell(dav_n_out) |-> $past(nrfd_n, 3))
    else $error("data valid before acceptors ready");
  a_accept_first: assert property ($rose(dav_n_out) && dav_oe |-> $past(ndac_n, 3))
    else $error("data valid dropped before acceptance");
  a_read_match: assert property ($past(resetn) |-> rd_end == exp_rd)
    else $error("read end flag wrong");
  a_write_eoi: assert property ($past(resetn) |-> wr_eoi == exp_wr)
    else $error("write end flag wrong");
  a_refuse_cic: assert property (
    op_start && op_code == OP_CMD && !cfg_is_cic |=> ##[0:1]
    (op_done && status_word[ST_ERR] && error_code_word == ERR_NOT_CIC))
    else $error("command accepted without control");
  a_tct_release: assert property (
    $rose(dav_n_out) && dav_oe && dio_n_out == ~CMD_TCT |-> ##[1:300] atn_n)
    else $error("attention kept after take-control byte");
endmodule : gct_cmd_tx_monitor
`default_nettype wire

/* File: verification/gct_acceptor.sv */
// Acceptor model on the far side of the instrument bus
`timescale 1ns/1ns
`default_nettype none
module gct_acceptor (
  input wire logic clk_sys,
  input wire logic dav_n,
  input wire logic [7:0] dio_n,
  input wire logic stall,
  input wire logic dead,
  output logic nrfd_n,
  output logic ndac_n
);
  logic [7:0] got[$];

  initial begin
    nrfd_n = 1'b0;
    ndac_n = 1'b0;
  end

  // Ready, take byte, accept, wait for release; stall slows, dead never readies
  always begin
    repeat (stall ? 40 : 2) @(posedge clk_sys);
    while (dav_n !== 1'b0 || dead) begin
      nrfd_n <= !dead;
      @(posedge clk_sys);
    end
    nrfd_n <= 1'b0;
    got.push_back(~dio_n);
    repeat (stall ? 20 : 1) @(posedge clk_sys);
    ndac_n <= 1'b1;
    while (dav_n !== 1'b1) @(posedge clk_sys);
    ndac_n <= 1'b0;
  end
endmodule : gct_acceptor
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the command transmitter
`timescale 1ns/1ns
`default_nettype none
module tb
  import gct_pkg::*;
;
  localparam logic [15:0] EOS_DEF = 16'h040D;
  logic clk_sys, resetn, op_start, op_done, cmd_valid, cmd_ready, cfg_is_cic;
  logic cfg_host_dma, cfg_sad_en, dma_enable, rd_end, wr_eoi, dio_oe, dav_oe;
  logic dav_n_out, atn_n, nrfd_n, ndac_n, stall, dead, dav_w, cfg_sys_ctrl, ifc_n;
  logic [2:0] op_code;
  logic [1:0] cfg_dma_channel, dma_channel;
  logic [4:0] cfg_dev_addr, cfg_sad;
  logic [7:0] cmd_data, rd_byte, wr_byte, dio_n_out, dio_w;
  logic [15:0] op_value, status_word, transfer_count, error_code_word;
  logic [15:0] string_end_setting, prev_eos;
  int bad_count, num_checks;

  // Released lines float high through bus pull-ups
  assign dav_w = dav_oe ? dav_n_out : 1'b1;
  assign dio_w = dio_oe ? dio_n_out : 8'hFF;

  gct_cmd_tx #(.TMO_CYCLES(5000)) gct_cmd_tx_inst (
    .clk_sys, .resetn, .op_start, .op_code, .op_value, .op_done, .cmd_data, .cmd_valid,
    .cmd_ready, .cfg_is_cic, .cfg_sys_ctrl, .cfg_host_dma, .cfg_dma_channel,
    .cfg_dma_default(1'b0), .cfg_eos_default(EOS_DEF), .cfg_dev_addr, .cfg_sad_en,
    .cfg_sad, .status_word, .transfer_count, .error_code_word, .dma_enable, .dma_channel,
    .string_end_setting, .rd_byte, .rd_end, .wr_byte, .wr_eoi, .dio_n_out, .dio_oe,
    .dav_n_out, .dav_oe, .atn_n, .nrfd_n, .ndac_n, .ifc_n
  );
  gct_acceptor gct_acceptor_inst (
    .clk_sys, .dav_n(dav_w), .dio_n(dio_w), .stall, .dead, .nrfd_n, .ndac_n
  );

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask : chk1

  // One host operation; bounded wait for its done pulse
  task automatic op(input logic [2:0] c, input logic [15:0] v);
    int n;
    op_start = 1'b1;
    op_code = c;
    op_value = v;
    tick;
    op_start = 1'b0;
    for (n = 0; n < 9000 && op_done !== 1'b1; n++) tick;
    chk1(op_done, 1'b1);
    tick; // Gap edge, also lets the end-of-transfer FIFO flush pass
  endtask : op

  // Bytes into the FIFO; valid held until the last is taken
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      cmd_data = q[i];
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) tick;
      tick;
    end
    cmd_valid = 1'b0;
  endtask : send

  task automatic chk_got(input logic [7:0] q[$]);
    chk(16'(gct_acceptor_inst.got.size()), 16'(q.size()));
    foreach (q[i]) chk({8'h0, gct_acceptor_inst.got[i]}, {8'h0, q[i]});
    gct_acceptor_inst.got.delete();
  endtask : chk_got

  task automatic t_refuse;
    cfg_is_cic = 1'b0;
    op(OP_CMD, 16'h0001);
    chk(error_code_word, ERR_NOT_CIC);
    chk1(status_word[ST_ERR], 1'b1);
    cfg_is_cic = 1'b1;
    $display("end t_refuse");
  endtask : t_refuse

  task automatic t_cmd;
    send({8'h14, 8'h08, 8'h18});
    op(OP_CMD, 16'h0003);
    chk_got({8'h14, 8'h08, 8'h18});
    chk(transfer_count, 16'h0003);
    chk1(status_word[ST_COMPLETION_FLAG], 1'b1);
    chk1(status_word[ST_ERR], 1'b0);
    tick;
    chk1(atn_n, 1'b0);
    chk1(status_word[ST_ATN], 1'b1);
    $display("end t_cmd");
  endtask : t_cmd

  task automatic t_clr;
    cfg_dev_addr = 5'h07;
    cfg_sad = 5'h0E;
    cfg_sad_en = 1'b1;
    op(OP_CLR, 16'h0000);
    chk_got({8'h27, 8'h6E, 8'h04, CMD_UNT, CMD_UNL});
    chk(transfer_count, 16'h0005);
    cfg_sad_en = 1'b0;
    op(OP_CLR, 16'h0000);
    chk_got({8'h27, 8'h04, CMD_UNT, CMD_UNL});
    chk(transfer_count, 16'h0004);
    $display("end t_clr");
  endtask : t_clr

  task automatic t_stops;
    send({CMD_TCT, CMD_UNL});
    op(OP_CMD, 16'h0002);
    chk(transfer_count, 16'h0001);
    chk1(atn_n, 1'b1);
    dead = 1'b1;
    send({CMD_UNL});
    op(OP_CMD, 16'h0001);
    chk1(status_word[ST_TIMO], 1'b1);
    chk(transfer_count, 16'h0000);
    // Own IFC is ignored, a foreign one ends the transfer
    send({CMD_UNL});
    op(OP_CMDA, 16'h0001);
    ifc_n = 1'b0;
    repeat (5) tick;
    chk1(status_word[ST_COMPLETION_FLAG], 1'b0);
    cfg_sys_ctrl = 1'b0;
    repeat (3) tick;
    chk1(status_word[ST_COMPLETION_FLAG], 1'b1);
    chk1(status_word[ST_TIMO], 1'b0);
    chk(transfer_count, 16'h0000);
    ifc_n = 1'b1;
    cfg_sys_ctrl = 1'b1;
    dead = 1'b0;
    gct_acceptor_inst.got.delete();
    $display("end t_stops");
  endtask : t_stops

  // Fill until refused, then drain against a slow acceptor
  task automatic t_fifo;
    logic [7:0] q[$];
    stall = 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) q.push_back(i[0] ? CMD_UNT : CMD_UNL);
    send(q);
    tick;
    chk1(cmd_ready, 1'b0);
    op(OP_CMD, 16'(FIFO_DEPTH));
    chk_got(q);
    chk(transfer_count, 16'(FIFO_DEPTH));
    chk1(cmd_ready, 1'b1);
    $display("end t_fifo");
  endtask : t_fifo

  task automatic t_async;
    int n;
    send({CMD_UNL, CMD_UNT});
    op(OP_CMDA, 16'h0002);
    chk1(status_word[ST_COMPLETION_FLAG], 1'b0);
    chk(transfer_count, 16'(FIFO_DEPTH));
    op(OP_DMA, 16'h0000);
    chk(error_code_word, ERR_PENDING);
    op(OP_WAIT, 16'h4100);
    for (n = 0; n < 9000 && status_word[ST_COMPLETION_FLAG] !== 1'b1; n++) tick;
    chk1(status_word[ST_COMPLETION_FLAG], 1'b1);
    chk(transfer_count, 16'h0002);
    tick;
    send({CMD_UNL, CMD_UNT});
    op(OP_CMDA, 16'h0002);
    op(OP_STOP, 16'h0000);
    tick;
    chk1(status_word[ST_COMPLETION_FLAG], 1'b1);
    chk(transfer_count, 16'h0000);
    stall = 1'b0;
    $display("end t_async");
  endtask : t_async

  task automatic t_dma;
    cfg_host_dma = 1'b1;
    for (int c = 1; c < 4; c++) begin
      cfg_dma_channel = c[1:0];
      tick;
      tick;
      chk({14'h0, dma_channel}, 16'(c));
    end
    op(OP_DMA, 16'h0001);
    chk1(dma_enable, 1'b1);
    chk(error_code_word, 16'h0000);
    op(OP_DMA, 16'h0000);
    chk1(dma_enable, 1'b0);
    chk(error_code_word, 16'h0001);
    cfg_dma_channel = 2'h0;
    op(OP_DMA, 16'h0001);
    chk(error_code_word, ERR_NO_CAP);
    cfg_host_dma = 1'b0;
    cfg_dma_channel = 2'h2;
    op(OP_DMA, 16'h0007);
    chk(error_code_word, ERR_NO_CAP);
    op(OP_EOS, EOS_DEF);
    op(OP_DMA, 16'h0000);
    chk(error_code_word, EOS_DEF);
    chk1(dma_enable, 1'b0);
    $display("end t_dma");
  endtask : t_dma

  task automatic eos_case(input logic [15:0] v, input logic [7:0] b, input logic r, input logic w);
    op(OP_EOS, v);
    chk(error_code_word, prev_eos);
    chk(string_end_setting, v);
    prev_eos = v;
    rd_byte = b;
    wr_byte = b;
    tick;
    tick;
    chk1(rd_end, r);
    chk1(wr_eoi, w);
  endtask : eos_case

  task automatic t_eos;
    prev_eos = EOS_DEF;
    eos_case(16'h0C0A, 8'h8A, 1'b1, 1'b1);
    eos_case(16'h1C0A, 8'h8A, 1'b0, 1'b0);
    eos_case(16'h1C0A, 8'h0A, 1'b1, 1'b1);
    eos_case(16'h040A, 8'h0A, 1'b1, 1'b0);
    eos_case(16'h080A, 8'h8A, 1'b0, 1'b1);
    op(OP_ONL, 16'h0000);
    tick;
    chk(string_end_setting, EOS_DEF);
    $display("end t_eos");
  endtask : t_eos

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    op_start = 1'b0;
    op_code = OP_WAIT;
    op_value = 16'h0000;
    cmd_data = 8'h00;
    cmd_valid = 1'b0;
    cfg_is_cic = 1'b1;
    cfg_sys_ctrl = 1'b1;
    ifc_n = 1'b1;
    cfg_host_dma = 1'b0;
    cfg_dma_channel = 2'h0;
    cfg_dev_addr = 5'h00;
    cfg_sad_en = 1'b0;
    cfg_sad = 5'h00;
    rd_byte = 8'h00;
    wr_byte = 8'h00;
    stall = 1'b0;
    dead = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    t_refuse;
    t_cmd;
    t_clr;
    t_stops;
    t_fifo;
    t_async;
    t_dma;
    t_eos;
    complete_run;
  end

  // Watchdog, well past the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    $display("BAD t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
    complete_run;
  end
endmodule : tb

bind gct_cmd_tx gct_cmd_tx_monitor gct_cmd_tx_monitor_inst (
  .clk_sys, .resetn, .op_start, .op_code, .op_done, .cfg_is_cic, .status_word,
  .error_code_word, .string_end_setting, .rd_byte, .rd_end, .wr_byte, .wr_eoi,
  .dio_n_out, .dio_oe, .dav_n_out, .dav_oe, .atn_n, .nrfd_n, .ndac_n
);
`default_nettype wire
